// ==== design/vrt_row_xfer.sv ====
// Video RAM row-transfer sequencer, strobe shift register and bank select
`timescale 1ns/1ps
`default_nettype none
`include "vrt_defs.svh"

module vrt_row_xfer
    import vrt_pkg::*;
(
    input  wire logic                      I_MCLK,
    input  wire logic                      I_RESET_N,
    input  wire logic                      I_CE,
    input  wire logic                      I_FRAME_START,
    input  wire logic [`VRT_CNT_W-1:0]     I_INITIAL_SHIFT_COUNT,
    input  wire logic [`VRT_CNT_W-1:0]     I_TRANSFER_DELAY_COUNT,
    input  wire logic                      I_HOST_ADDR_VALID,
    input  wire logic [`VRT_ROW_W-1:0]     I_HOST_ROW_ADDR,
    input  wire logic                      I_HOST_BUS_GRANT,
    output logic                           O_CTRL_BUS_REQ,
    output logic                           O_XFER_STROBE_N,
    output logic [`VRT_ROW_W-1:0]          O_ROW_ADDR,
    output logic                           O_ADDR_OE,
    output logic                           O_CTRL_CYCLE_ACTIVE,
    output vrt_strobes_t                   O_STROBES,
    output logic [1:0]                     O_SERIAL_OUT_EN
);

    //--------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------
    vrt_state_t                 state;
    vrt_state_t                 next_state;
    logic [`VRT_CNT_W-1:0]      cnt;
    logic [`VRT_CNT_W-1:0]      next_cnt;
    logic                       next_bus_req;
    logic                       grant_meta;
    logic                       grant_sync;
    logic                       grant_prev;
    logic                       grant_rise;
    logic                       ctrl_cycle_active;
    logic [`VRT_SHREG_LEN-1:0]  shreg;
    logic                       xfer_strobe_n;
    logic                       xfer_rise;
    logic                       xfer_strobe_prev_n;
    logic                       bank;
    logic [`VRT_ROW_W-1:0]      row_addr;
    logic                       start_cycle;

    //--------------------------------------------------------------------
    // Transfer sequencer
    //--------------------------------------------------------------------
    // Next state: frame start always restarts the sequence
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt + `VRT_CNT_ONE;
        if (I_FRAME_START)
        begin
            next_state = VRT_DELAY;
            next_cnt   = `VRT_CNT_ZERO;
        end
        else
        begin
            case (state)
                VRT_IDLE:
                begin
                    next_cnt = `VRT_CNT_ZERO;
                end
                VRT_WAIT:
                begin
                    // Counting the initial shift count after a transfer
                    if (next_cnt >= I_INITIAL_SHIFT_COUNT)
                    begin
                        next_state = VRT_DELAY;
                        next_cnt   = `VRT_CNT_ZERO;
                    end
                end
                VRT_DELAY:
                begin
                    // Last delay cycle is the transfer cycle itself
                    if (next_cnt + `VRT_CNT_ONE >= I_TRANSFER_DELAY_COUNT)
                    begin
                        next_state = VRT_XFER;
                        next_cnt   = `VRT_CNT_ZERO;
                    end
                end
                VRT_XFER:
                begin
                    next_state = VRT_WAIT;
                    next_cnt   = `VRT_CNT_ZERO;
                end
                default:
                begin
                    next_state = VRT_IDLE;
                    next_cnt   = `VRT_CNT_ZERO;
                end
            endcase
        end
    end

    // Request stays low for the hidden overhead at the head of the delay
    always_comb
    begin
        next_bus_req = 1'b0;
        if (next_state == VRT_XFER)
        begin
            next_bus_req = 1'b1;
        end
        else if (next_state == VRT_DELAY && next_cnt >= `VRT_OVERHEAD)
        begin
            next_bus_req = 1'b1;
        end
    end

    assign start_cycle = (next_state == VRT_DELAY) && (state != VRT_DELAY || I_FRAME_START);

    // State and counter
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            state <= VRT_IDLE;
            cnt   <= `VRT_CNT_ZERO;
        end
        else if (I_CE)
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // Request and transfer strobe, both registered; request drops with transfer
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            O_CTRL_BUS_REQ <= 1'b0;
            xfer_strobe_n  <= 1'b1;
        end
        else if (I_CE)
        begin
            O_CTRL_BUS_REQ <= next_bus_req;
            xfer_strobe_n  <= !(next_state == VRT_XFER);
        end
    end

    assign O_XFER_STROBE_N = xfer_strobe_n;

    //--------------------------------------------------------------------
    // Row address
    //--------------------------------------------------------------------
    // Loaded from the host or advanced at the start of every transfer cycle, before the grant
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            row_addr <= `VRT_ROW_RESET;
        end
        else if (I_CE && start_cycle)
        begin
            if (I_HOST_ADDR_VALID)
            begin
                row_addr <= I_HOST_ROW_ADDR;
            end
            else
            begin
                row_addr <= row_addr + `VRT_ROW_ONE;
            end
        end
    end

    // Address stays stable through the whole cycle, so both strobe edges see it
    assign O_ROW_ADDR = row_addr;
    assign O_ADDR_OE  = ctrl_cycle_active;

    //--------------------------------------------------------------------
    // Grant synchroniser and bus-cycle flag
    //--------------------------------------------------------------------
    // Grant comes from the host's clock; two flops before use
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            grant_meta <= 1'b0;
            grant_sync <= 1'b0;
            grant_prev <= 1'b0;
        end
        else if (I_CE)
        begin
            grant_meta <= I_HOST_BUS_GRANT;
            grant_sync <= grant_meta;
            grant_prev <= grant_sync;
        end
    end

    assign grant_rise = grant_sync && !grant_prev;

    // Set on grant rise wins over the clear from the transfer strobe
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            ctrl_cycle_active <= 1'b0;
        end
        else if (I_CE)
        begin
            if (grant_rise)
            begin
                ctrl_cycle_active <= 1'b1;
            end
            else if (!xfer_strobe_n)
            begin
                ctrl_cycle_active <= 1'b0;
            end
        end
    end

    // High level deselects the host's address-latch control
    assign O_CTRL_CYCLE_ACTIVE = ctrl_cycle_active;

    //--------------------------------------------------------------------
    // Strobe shift register
    //--------------------------------------------------------------------
    // A one walks in while the cycle lasts; cycle end clears it for precharge
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            shreg <= `VRT_SHREG_RESET;
        end
        else if (I_CE)
        begin
            if (!ctrl_cycle_active)
            begin
                shreg <= `VRT_SHREG_RESET;
            end
            else
            begin
                shreg <= {shreg[`VRT_SHREG_LEN-2:0], 1'b1};
            end
        end
    end

    // Taps skip the first stages; transfer-enable falls before row strobe
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            O_STROBES <= '{xfer_oe_n: 1'b1, row_strobe_n: 1'b1, col_strobe_n: 1'b1};
        end
        else if (I_CE)
        begin
            O_STROBES.xfer_oe_n    <= !shreg[`VRT_TAP_XOE];
            O_STROBES.row_strobe_n <= !shreg[`VRT_TAP_ROW];
            O_STROBES.col_strobe_n <= !shreg[`VRT_TAP_COL];
        end
    end

    //--------------------------------------------------------------------
    // Bank select and serial output enables
    //--------------------------------------------------------------------
    // Bank bit latched as the transfer strobe rises
    assign xfer_rise = xfer_strobe_n && !xfer_strobe_prev_n;

    // Previous strobe resets high, so no false rise follows reset
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            xfer_strobe_prev_n <= 1'b1;
            bank               <= 1'b0;
        end
        else if (I_CE)
        begin
            xfer_strobe_prev_n <= xfer_strobe_n;
            if (xfer_rise)
            begin
                bank <= row_addr[`VRT_BANK_BIT];
            end
        end
    end

    // Enables move one serial clock later, so the swap is clean
    always_ff @(posedge I_MCLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            O_SERIAL_OUT_EN <= `VRT_SOE_RESET;
        end
        else if (I_CE)
        begin
            O_SERIAL_OUT_EN <= {bank, !bank};
        end
    end

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    property p_one_bank;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        $onehot(O_SERIAL_OUT_EN);
    endproperty
    a_one_bank: assert property (p_one_bank) else $error("both or no banks enabled");

    property p_xoe_before_row;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        $fell(O_STROBES.row_strobe_n) |-> !O_STROBES.xfer_oe_n && !$past(O_STROBES.xfer_oe_n);
    endproperty
    a_xoe_before_row: assert property (p_xoe_before_row) else $error("row fell without transfer enable");

    property p_cycle_set;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_CE && grant_rise) |=> ctrl_cycle_active;
    endproperty
    a_cycle_set: assert property (p_cycle_set) else $error("bus-cycle flag missed grant");

    property p_cycle_clear;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_CE && !xfer_strobe_n && !grant_rise) |=> !ctrl_cycle_active;
    endproperty
    a_cycle_clear: assert property (p_cycle_clear) else $error("bus-cycle flag held past transfer");

    property p_idle_clear;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_CE && !ctrl_cycle_active) |=> (shreg == `VRT_SHREG_RESET);
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("shift register not cleared");

    property p_addr_delay;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        $rose(ctrl_cycle_active) |-> O_STROBES.xfer_oe_n [*3];
    endproperty
    a_addr_delay: assert property (p_addr_delay) else $error("strobe too soon after grant");

    property p_req_with_xfer;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        $fell(xfer_strobe_n) |-> O_CTRL_BUS_REQ ##1 (!I_CE || !O_CTRL_BUS_REQ || !xfer_strobe_n);
    endproperty
    a_req_with_xfer: assert property (p_req_with_xfer) else $error("request not tied to transfer");

    property p_frame_start;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_CE && I_FRAME_START) |=> (state == VRT_DELAY) && (cnt == `VRT_CNT_ZERO);
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame start did not begin cycle");

    property p_wait_len;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_CE && state == VRT_WAIT && !I_FRAME_START && cnt + `VRT_CNT_ONE < I_INITIAL_SHIFT_COUNT)
        |=> (state == VRT_WAIT);
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("initial count cut short");

    property p_no_early_req;
        @(posedge I_MCLK) disable iff (!I_RESET_N)
        (state == VRT_DELAY && cnt < `VRT_OVERHEAD) |-> !O_CTRL_BUS_REQ;
    endproperty
    a_no_early_req: assert property (p_no_early_req) else $error("request inside overhead");

endmodule : vrt_row_xfer

`default_nettype wire

// ==== design/vrt_defs.svh ====
// Constants for the video RAM row-transfer control block
// Overview of operation
// - Hold the transfer/output-enable strobe low when the row strobe falls to reload.
// - Row address valid at row strobe fall; start bit address at column strobe fall.
// - Transfer completes when the transfer/output-enable strobe rises.
// - After grant drive a 22-bit row address, incremented unless host supplies it.
// - All video RAM strobes for controller cycles come from the strobe shift register in this block.
// - Bus request and transfer are timed by initial shift count and transfer delay.
// - Strobes come from a one shifted through eight stages, inverted at outputs.
// - First three stages drive nothing, giving row address time after grant.
// - End of bus cycle clears the strobe shift register, releasing every strobe.
// - Bus-cycle flag rises on the rising edge of the bus grant.
// - Bus-cycle flag falls when transfer goes low; high deselects address-latch logic.
// - Only one bank's serial output enable is active at any time.
// - Bank bit latched on transfer strobe rise; enables change on serial clock edge.
// - Each frame starts a transfer cycle at first back porch, done after delay.
// - After transfer, count initial shift count, then transfer delay, then strobe low.
// - Row transfers repeat every initial count plus transfer delay shift clocks.
// - Four clock overhead sits inside the delay, before the bus request rises.
// - Bank select uses the lowest row-address bit, alternating each transfer while the row address is incremented.
`ifndef VRT_DEFS_SVH
`define VRT_DEFS_SVH

`define VRT_ROW_W        22
`define VRT_CNT_W        16
`define VRT_SHREG_LEN    8
`define VRT_ADDR_DELAY   3
`define VRT_TAP_XOE      3
`define VRT_TAP_ROW      4
`define VRT_TAP_COL      6
`define VRT_OVERHEAD     16'h0004
`define VRT_CNT_ONE      16'h0001
`define VRT_CNT_ZERO     16'h0000
`define VRT_ROW_ONE      22'h000001
`define VRT_ROW_RESET    22'h000000
`define VRT_SHREG_RESET  8'h00
`define VRT_SOE_RESET    2'h1
`define VRT_BANK_BIT     0

`endif

// ==== design/vrt_pkg.sv ====
// Types for the video RAM row-transfer control block
`include "vrt_defs.svh"
package vrt_pkg;

    // Transfer sequencer states, one-hot
    typedef enum logic [3:0]
    {
        VRT_IDLE  = 4'h1,
        VRT_WAIT  = 4'h2,
        VRT_DELAY = 4'h4,
        VRT_XFER  = 4'h8
    } vrt_state_t;

    // Video RAM strobes, active low
    typedef struct packed
    {
        logic xfer_oe_n;
        logic row_strobe_n;
        logic col_strobe_n;
    } vrt_strobes_t;

endpackage : vrt_pkg

// ==== verif/vrt_host_model.sv ====
// Host memory controller model: answers a bus request with a grant
`timescale 1ns/1ps
`default_nettype none

module vrt_host_model
(
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_req,
    input  wire logic [2:0] i_lat,
    output logic            o_grant
);
    int wait_cnt;

    // Grant after a latency that stands for the host finishing its own cycle;
    // release at once when the request drops, so a late grant never lingers
    always @(negedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_grant  <= 1'b0;
            wait_cnt <= 0;
        end
        else if (!i_req)
        begin
            o_grant  <= 1'b0;
            wait_cnt <= 0;
        end
        else if (wait_cnt + 1 >= int'(i_lat))
            o_grant <= 1'b1;
        else
            wait_cnt <= wait_cnt + 1;
    end
endmodule : vrt_host_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the row-transfer control block
`timescale 1ns/1ps
`default_nettype none
`include "vrt_defs.svh"

module tb_top
    import vrt_pkg::*;
;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  ce = 1'b0;
    logic                  fs = 1'b0;
    logic                  hav = 1'b0;
    logic [`VRT_CNT_W-1:0] isc = `VRT_CNT_ONE;
    logic [`VRT_CNT_W-1:0] tdc = `VRT_CNT_ONE;
    logic [`VRT_ROW_W-1:0] hra = `VRT_ROW_RESET;
    logic [2:0]            lat = 3'h1;
    logic                  grant;
    logic                  req;
    logic                  xfer_n;
    logic                  addr_oe;
    logic                  cyc;
    logic [`VRT_ROW_W-1:0] row_addr;
    vrt_strobes_t          stb;
    logic [1:0]            serial_out_en;
    logic                  ce_q = 1'b0;
    logic                  fs_q = 1'b0;
    logic                  hav_q = 1'b0;
    logic                  g_q = 1'b0;
    logic [`VRT_ROW_W-1:0] hra_q = `VRT_ROW_RESET;
    logic [`VRT_ROW_W-1:0] exp_addr = `VRT_ROW_RESET;
    logic                  prev_x = 1'b1;
    logic                  rb = 1'b0;
    logic                  soe_pend = 1'b0;
    logic                  mon = 1'b0;
    int                    k = 0;
    int                    gc = 0;
    int                    fc = 0;
    int                    fl = 3;
    int                    d = 21;
    int                    i_cnt = 1;
    int                    dq = 21;
    int                    iq = 1;
    int                    err_total = 0;
    int                    cmp_count = 0;
    int                    seed = 77539;

    always #10 clk = ~clk;

    vrt_row_xfer dut (.I_MCLK(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_FRAME_START(fs),
        .I_INITIAL_SHIFT_COUNT(isc), .I_TRANSFER_DELAY_COUNT(tdc), .I_HOST_ADDR_VALID(hav),
        .I_HOST_ROW_ADDR(hra), .I_HOST_BUS_GRANT(grant), .O_CTRL_BUS_REQ(req),
        .O_XFER_STROBE_N(xfer_n), .O_ROW_ADDR(row_addr), .O_ADDR_OE(addr_oe),
        .O_CTRL_CYCLE_ACTIVE(cyc), .O_STROBES(stb), .O_SERIAL_OUT_EN(serial_out_en));

    vrt_host_model host (.i_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_lat(lat), .o_grant(grant));

    // ----------------------------------------------------------------
    // Expectations and shared tasks
    // ----------------------------------------------------------------
    // Cycle k counts from the frame start; one period is delay plus initial count
    function automatic logic f_xfer(input int kk, input int dd, input int ii);
        return ((kk - 1) % (dd + ii)) == dd - 1;
    endfunction : f_xfer

    // Request waits out the four-cycle overhead, then holds to the transfer
    function automatic logic f_req(input int kk, input int dd, input int ii);
        return ((kk - 1) % (dd + ii)) >= 4 && ((kk - 1) % (dd + ii)) <= dd - 1;
    endfunction : f_req

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : chk

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic chk_reset();
        logic ok;
        ok = req === 1'b0 && xfer_n === 1'b1 && stb === 3'h7 && cyc === 1'b0 && addr_oe === 1'b0;
        chk(ok && row_addr === `VRT_ROW_RESET && serial_out_en === 2'h1, "reset values");
    endtask : chk_reset

    // One frame start, then two full periods; cr adds random clock-enable gaps
    task automatic run(input int dd, input int ii, input logic hv, input logic [`VRT_ROW_W-1:0] ha,
                       input logic cr);
        int n;
        @(negedge clk);
        d = dd;
        i_cnt = ii;
        hav = hv;
        hra = ha;
        tdc = dd[`VRT_CNT_W-1:0];
        isc = ii[`VRT_CNT_W-1:0];
        lat = 3'(1 + {$random(seed)} % 4);
        fs = 1'b1;
        ce = 1'b1;
        @(negedge clk);
        fs = 1'b0;
        n = 0;
        while (k < dd + 2 * (dd + ii) + 4 && n < 3000)
        begin
            ce = cr ? (($random(seed) & 7) != 0) : 1'b1;
            @(negedge clk);
            n++;
        end
        if (n >= 3000)
        begin
            err_total++;
            test_done();
        end
    endtask : run

    // ----------------------------------------------------------------
    // Monitor: inputs captured at the edge, outputs judged at the falling edge
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        ce_q <= ce;
        fs_q <= fs;
        hav_q <= hav;
        hra_q <= hra;
        g_q <= grant;
        dq <= d;
        iq <= i_cnt;
    end

    // Counters advance only on enabled edges, so frozen cycles expect frozen outputs
    always @(negedge clk)
    begin
        if (mon)
        begin
            if (ce_q)
            begin
                if (fs_q)
                    k = 1;
                else if (k > 0)
                    k++;
                if (k > 0 && (k - 1) % (dq + iq) == 0)
                    exp_addr = hav_q ? hra_q : exp_addr + `VRT_ROW_ONE;
                gc = g_q ? gc + 1 : 0;
                fc = (cyc === 1'b1) ? fc + 1 : 0;
                fl = (cyc === 1'b1) ? 0 : fl + 1;
                if (prev_x === 1'b0) chk(cyc === 1'b0, "flag after transfer");
                prev_x = xfer_n;
            end
            if (k > 0) chk(xfer_n === !f_xfer(k, dq, iq), "transfer timing");
            if (k > 0) chk(req === f_req(k, dq, iq), "request timing");
            chk(row_addr === exp_addr, "row address");
            chk(addr_oe === cyc, "address drive");
            if (gc == 2 || gc == 3) chk(cyc === (gc == 3), "flag after grant");
            if (cyc === 1'b1) chk(stb === {fc < 6, fc < 7, fc < 9}, "strobe order");
            if (fl >= 3) chk(stb === 3'h7, "strobes released");
            chk(serial_out_en === 2'h1 || serial_out_en === 2'h2, "one bank enabled");
            if (xfer_n === 1'b0)
            begin
                rb = row_addr[`VRT_BANK_BIT];
                soe_pend = 1'b1;
            end
            if (soe_pend && fl == 3)
            begin
                chk(serial_out_en === {rb, !rb}, "bank select");
                soe_pend = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        repeat (3) @(negedge clk);
        chk_reset();
        rst_n = 1'b1;
        mon = 1'b1;
        // Shortest wait, then top row from host, then wrap to zero with gaps
        run(21, 1, 1'b0, `VRT_ROW_RESET, 1'b0);
        run(40, 30, 1'b1, 22'h3FFFFF, 1'b0);
        run(24, 5, 1'b0, `VRT_ROW_RESET, 1'b1);
        repeat (5)
            run(21 + int'({$random(seed)} % 20), 1 + int'({$random(seed)} % 30), 1'($random(seed)),
                22'($random(seed)), 1'b1);
        // Reset in the middle of a transfer window
        repeat (12) @(negedge clk);
        rst_n = 1'b0;
        mon = 1'b0;
        @(negedge clk);
        chk_reset();
        // Second release: bench state starts over, then one more frame
        k = 0;
        fc = 0;
        gc = 0;
        fl = 3;
        prev_x = 1'b1;
        soe_pend = 1'b0;
        exp_addr = `VRT_ROW_RESET;
        rst_n = 1'b1;
        mon = 1'b1;
        run(22, 3, 1'b0, `VRT_ROW_RESET, 1'b1);
        test_done();
    end

    // Runs take under two thousand cycles; 20000 means a hang
    initial
    begin
        #400000;
        err_total++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
